// ---- design/tcs_i2c_slave.sv ----
// Purpose: two-wire slave port with register pointer, clock stretch and sequential read
// Assumes: scl and sda are pins from another domain; register file sits outside
// Notes: the shift-in register runs on scl itself, framing runs on clock_i
`timescale 1ns/10ps
`include "tcs_params.svh"

module tcs_i2c_slave #(
  parameter int STRETCH_CYCLES = (`TCS_STRETCH_NS * `TCS_CLK_MHZ + 999) / 1000
) (
  // system clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // link clock, the scl wire itself
  input wire logic link_scl_i,
  // bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // address select pins
  input wire logic [2:0] address_select_i,
  // register file side
  output logic [7:0] ptr_o,
  input wire logic [7:0] rd_data_i,
  output logic rd_strobe_o,
  output tcs_pkg::tcs_wr_t wr_o,
  output logic busy_o
);

  localparam int STRETCH_LEN = (STRETCH_CYCLES < 1) ? 1 : STRETCH_CYCLES;

  // link domain: byte assembled on scl rising edges
  logic [7:0] link_rx;
  logic [7:0] next_link_rx;

  // sys domain state
  tcs_pkg::tcs_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] ptr, next_ptr;
  logic [7:0] tx, next_tx;
  logic first, next_first;
  logic rw, next_rw;
  logic mack, next_mack;
  logic sda_drv, next_sda_drv;
  logic scl_drv, next_scl_drv;
  logic [15:0] stretch_cnt, next_stretch_cnt;
  logic rd_pulse, next_rd_pulse;
  tcs_pkg::tcs_wr_t wr, next_wr;

  // synchronisers
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic [2:0] asel_s1, asel_s2;

  logic start_det, stop_det, scl_rise, scl_fall, addr_hit;

  always_comb begin
    next_link_rx = {link_rx[6:0], sda_i};
  end

  // no reset: pure data, only read once eight edges follow a start
  always_ff @(posedge link_scl_i) begin
    link_rx <= next_link_rx;
  end

  // two flops per pin, third flop only for edge finding
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      asel_s1 <= 3'h0;
      asel_s2 <= 3'h0;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      asel_s1 <= address_select_i;
      asel_s2 <= asel_s1;
    end
  end

  // bus conditions and edges
  // start detect
  assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  // fixed upper bits plus pins; link_rx is quiet while scl is low
  assign addr_hit = (link_rx[7:1] == {`TCS_ADDR_UPPER, asel_s2});

  // protocol next state
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_ptr = ptr;
    next_tx = tx;
    next_first = first;
    next_rw = rw;
    next_mack = mack;
    next_sda_drv = sda_drv;
    next_scl_drv = scl_drv;
    next_stretch_cnt = stretch_cnt;
    next_rd_pulse = 1'b0;
    next_wr = wr;
    next_wr.valid = 1'b0;
    if (start_det) begin
      // abort on start, release both lines
      next_state = tcs_pkg::TCS_ADDR;
      next_bit_cnt = `TCS_BIT_ZERO;
      next_sda_drv = 1'b0;
      next_scl_drv = 1'b0;
      next_stretch_cnt = `TCS_STRETCH_RST;
    end else if (stop_det) begin
      next_state = tcs_pkg::TCS_IDLE;
      next_bit_cnt = `TCS_BIT_ZERO;
      next_sda_drv = 1'b0;
      next_scl_drv = 1'b0;
      next_stretch_cnt = `TCS_STRETCH_RST;
    end else begin
      // rising edges count bit slots, the ninth is the acknowledge
      if (scl_rise && state != tcs_pkg::TCS_IDLE && bit_cnt < `TCS_ACK_SLOT) begin
        next_bit_cnt = 4'(bit_cnt + 4'h1);
      end
      if (scl_rise && state == tcs_pkg::TCS_READ && bit_cnt == `TCS_BYTE_LAST) begin
        next_mack = !sda_s2;
      end
      unique case (state)
        tcs_pkg::TCS_IDLE: begin
          next_bit_cnt = `TCS_BIT_ZERO;
        end
        tcs_pkg::TCS_ADDR: begin
          if (scl_fall && bit_cnt == `TCS_BYTE_LAST) begin
            if (addr_hit) begin
              next_sda_drv = 1'b1;
              next_rw = link_rx[0];
            end else begin
              next_state = tcs_pkg::TCS_IDLE;
            end
          end else if (scl_fall && bit_cnt == `TCS_ACK_SLOT) begin
            next_sda_drv = 1'b0;
            next_bit_cnt = `TCS_BIT_ZERO;
            if (rw) begin
              next_state = tcs_pkg::TCS_READ;
              next_scl_drv = 1'b1;
              next_stretch_cnt = 16'(STRETCH_LEN);
            end else begin
              next_state = tcs_pkg::TCS_WRITE;
              next_first = 1'b1;
            end
          end
        end
        tcs_pkg::TCS_WRITE: begin
          if (scl_fall && bit_cnt == `TCS_BYTE_LAST) begin
            next_sda_drv = 1'b1;
            if (first) begin
              // all eight bits kept, upper ones not policed
              next_ptr = link_rx;
              next_first = 1'b0;
            end else begin
              // later bytes go to the pointed register
              next_wr.valid = 1'b1;
              next_wr.ptr = ptr;
              next_wr.data = link_rx;
            end
          end else if (scl_fall && bit_cnt == `TCS_ACK_SLOT) begin
            next_sda_drv = 1'b0;
            next_bit_cnt = `TCS_BIT_ZERO;
          end
        end
        tcs_pkg::TCS_READ: begin
          if (stretch_cnt != `TCS_STRETCH_RST) begin
            // hold scl, fetch byte at the end of the stretch
            next_stretch_cnt = 16'(stretch_cnt - 16'h0001);
            if (stretch_cnt == 16'h0001) begin
              next_scl_drv = 1'b0;
              next_tx = rd_data_i;
              next_sda_drv = !rd_data_i[7];
              next_rd_pulse = 1'b1;
            end
          end else if (scl_fall && bit_cnt != `TCS_BIT_ZERO && bit_cnt < `TCS_BYTE_LAST) begin
            // next bit placed while scl low
            next_tx = {tx[6:0], 1'b0};
            next_sda_drv = !tx[6];
          end else if (scl_fall && bit_cnt == `TCS_BYTE_LAST) begin
            // master owns the acknowledge slot
            next_sda_drv = 1'b0;
          end else if (scl_fall && bit_cnt == `TCS_ACK_SLOT) begin
            next_bit_cnt = `TCS_BIT_ZERO;
            if (mack) begin
              next_ptr = 8'(ptr + 8'h01);
              next_scl_drv = 1'b1;
              next_stretch_cnt = 16'(STRETCH_LEN);
            end else begin
              next_state = tcs_pkg::TCS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // protocol registers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= tcs_pkg::TCS_IDLE;
      bit_cnt <= `TCS_BIT_ZERO;
      ptr <= `TCS_PTR_RST;
      tx <= 8'h00;
      first <= 1'b0;
      rw <= 1'b0;
      mack <= 1'b0;
      sda_drv <= 1'b0;
      scl_drv <= 1'b0;
      stretch_cnt <= `TCS_STRETCH_RST;
      rd_pulse <= 1'b0;
      wr <= '0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      ptr <= next_ptr;
      tx <= next_tx;
      first <= next_first;
      rw <= next_rw;
      mack <= next_mack;
      sda_drv <= next_sda_drv;
      scl_drv <= next_scl_drv;
      stretch_cnt <= next_stretch_cnt;
      rd_pulse <= next_rd_pulse;
      wr <= next_wr;
    end
  end

  // pins: open drain, only ever pulled low
  // scl pulled only by the stretch flop
  assign scl_o = 1'b0;
  assign scl_oe_n_o = !scl_drv;
  assign sda_o = 1'b0;
  assign sda_oe_n_o = !sda_drv;
  assign ptr_o = ptr;
  assign rd_strobe_o = rd_pulse;
  assign wr_o = wr;
  assign busy_o = (state != tcs_pkg::TCS_IDLE);

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_start_enter: assert property (start_det |=> state == tcs_pkg::TCS_ADDR && bit_cnt == 4'h0)
    else $error("start not taken");
  a_stop_idle: assert property (stop_det |=> state == tcs_pkg::TCS_IDLE)
    else $error("stop not taken");
  a_abort_release: assert property ((start_det || stop_det) |=> sda_oe_n_o && scl_oe_n_o)
    else $error("lines held after abort");
  a_byte_ack: assert property (state == tcs_pkg::TCS_WRITE && scl_fall && bit_cnt == 4'h8 && !start_det && !stop_det
    |=> !sda_oe_n_o)
    else $error("write byte not acknowledged");
  a_addr_miss: assert property (state == tcs_pkg::TCS_ADDR && scl_fall && bit_cnt == 4'h8 && !addr_hit
    && !start_det && !stop_det |=> sda_oe_n_o && state == tcs_pkg::TCS_IDLE)
    else $error("foreign address answered");
  a_dir_read: assert property (state == tcs_pkg::TCS_ADDR && scl_fall && bit_cnt == 4'h9 && rw
    && !start_det && !stop_det |=> state == tcs_pkg::TCS_READ && !scl_oe_n_o)
    else $error("read not entered");
  a_ptr_keep: assert property (state == tcs_pkg::TCS_IDLE || state == tcs_pkg::TCS_ADDR |=> $stable(ptr))
    else $error("pointer lost between transfers");
  a_ptr_load: assert property (state == tcs_pkg::TCS_WRITE && first && scl_fall && bit_cnt == 4'h8
    && !start_det && !stop_det |=> ptr == $past(link_rx) && !wr_o.valid)
    else $error("pointer byte not loaded");
  a_nak_release: assert property (state == tcs_pkg::TCS_READ && stretch_cnt == 16'h0 && scl_fall
    && bit_cnt == 4'h9 && !mack && !start_det && !stop_det |=> state == tcs_pkg::TCS_IDLE ##1 sda_oe_n_o)
    else $error("sda held after not-acknowledge");
  a_stretch_hold: assert property ($fell(scl_oe_n_o) |-> !scl_oe_n_o [*8])
    else $error("stretch too short");
  a_seq_inc: assert property (state == tcs_pkg::TCS_READ && stretch_cnt == 16'h0 && scl_fall && bit_cnt == 4'h9
    && mack && !start_det && !stop_det |=> ptr == 8'($past(ptr) + 8'h01))
    else $error("pointer not advanced");
  a_sda_low_scl: assert property ($changed(sda_oe_n_o) && !$past(start_det || stop_det) |-> !$past(scl_s2))
    else $error("sda moved while scl high");
  a_scl_stretch: assert property (!scl_oe_n_o |-> state == tcs_pkg::TCS_READ && stretch_cnt != 16'h0)
    else $error("scl driven outside stretch");

  c_write_byte: cover property (wr_o.valid);
  c_read_byte: cover property (rd_strobe_o ##[1:1000] state == tcs_pkg::TCS_IDLE);
  c_seq_read: cover property (rd_strobe_o && ptr != 8'h00);
  c_abort: cover property (start_det && state == tcs_pkg::TCS_WRITE);

endmodule

// ---- design/tcs_params.svh ----
// Purpose: constants of the thermocouple sensor two-wire slave port
// Assumes: 125 MHz system clock
// Notes: times are kept in their own unit, counts derive from them
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

// fixed upper four address bits, low three come from the select pins
`define TCS_ADDR_UPPER 4'hc
// system clock rate and clock stretch interval
`define TCS_CLK_MHZ 125
`define TCS_STRETCH_NS 60000
// bit slots counted in scl rising edges
`define TCS_BYTE_LAST 4'h8
`define TCS_ACK_SLOT 4'h9
`define TCS_BIT_ZERO 4'h0
// reset values
`define TCS_PTR_RST 8'h00
`define TCS_STRETCH_RST 16'h0000

`endif

// ---- design/tcs_pkg.sv ----
// Purpose: types of the thermocouple sensor two-wire slave port
// Assumes: used with tcs_params.svh
// Notes: states are one-hot
package tcs_pkg;

  typedef enum logic [3:0] {
    TCS_IDLE  = 4'h1,
    TCS_ADDR  = 4'h2,
    TCS_WRITE = 4'h4,
    TCS_READ  = 4'h8
  } tcs_state_t;

  // register write towards the register file
  typedef struct packed {
    logic valid;
    logic [7:0] ptr;
    logic [7:0] data;
  } tcs_wr_t;

endpackage

// ---- sim/sensor_i2c_slave_port_tb.sv ----
// Purpose: self-checking bench of the two-wire slave port
// Assumes: master model on the far side, register file stand-in here
// Notes: stretch shortened to 12 cycles
`timescale 1ns/10ps
`include "tcs_params.svh"
module sensor_i2c_slave_port_tb;
  logic clk;
  logic rst;
  logic [2:0] sel;
  logic [7:0] rdat;
  logic [7:0] regs [16];
  logic m_scl, m_sda, scl_w, sda_w;
  logic scl_oe_n, scl_v, sda_oe_n, sda_v, rd_stb, busy;
  logic [7:0] ptr;
  tcs_pkg::tcs_wr_t wr;
  logic [15:0] exp_q [$];
  logic [15:0] seed;
  int n_fail = 0;
  int tests_run = 0;
  // shortened stretch so the run stays small
  localparam int STRETCH = 12;
  int stretch_n = 0;

  // open-drain wires with pull-ups
  assign scl_w = !m_scl && (scl_oe_n || scl_v);
  assign sda_w = !m_sda && (sda_oe_n || sda_v);

  tcs_i2c_slave #(.STRETCH_CYCLES(STRETCH)) i_dut (.clock_i(clk), .sys_rst_i(rst), .link_scl_i(scl_w),
    .scl_i(scl_w), .scl_o(scl_v), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_v),
    .sda_oe_n_o(sda_oe_n), .address_select_i(sel), .ptr_o(ptr), .rd_data_i(rdat),
    .rd_strobe_o(rd_stb), .wr_o(wr), .busy_o(busy));
  tcs_master_model i_master (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl), .sda_low_o(m_sda));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // register file stand-in, data follows the pointer
  always @(posedge clk) rdat <= regs[ptr[3:0]];

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  // watcher: each register-side pulse takes the oldest note; a stray pulse meets x
  always @(posedge clk) begin
    if (wr.valid === 1'b1 || rd_stb === 1'b1) begin
      if (exp_q.size() == 0) exp_q.push_back(16'hxxxx);
      check(wr.valid ? {wr.ptr, wr.data} : {ptr, 8'h00}, exp_q.pop_front(), "register side");
    end
  end

  // stretch watcher: each hold of scl must last the configured cycles
  always @(posedge clk) begin
    if (scl_oe_n === 1'b0) begin
      stretch_n <= stretch_n + 1;
    end else if (stretch_n != 0) begin
      check(16'(stretch_n), 16'(STRETCH), "stretch length");
      stretch_n <= 0;
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog, the run needs about 240 us, mostly bus free waits
  initial begin
    #400000;
    n_fail++;
    tally_and_finish;
  end

  // start plus address byte, ack compared
  task automatic addr(input logic [2:0] a, input logic rw, input logic want);
    logic [7:0] rx;
    logic ack;
    i_master.start_c;
    i_master.xfer({`TCS_ADDR_UPPER, a, rw}, 8, rx);
    i_master.bit_x(1'b1, ack);
    check({15'h0, ack}, {15'h0, want}, "address ack");
  endtask

  initial begin
    logic [7:0] rx;
    logic ack;
    logic [7:0] p;
    rst = 1'b1;
    sel = 3'h0;
    seed = 16'hc233;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      regs[i] = seed[7:0];
    end
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check({ptr, 5'h0, busy, sda_oe_n, scl_oe_n}, 16'h0003, "reset state");
    // every select setting, matching and mismatching
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) sel <= i[2:0];
      repeat (4) @(posedge clk);
      addr(i[2:0], 1'b0, 1'b0);
      i_master.stop_c;
      addr(~i[2:0], 1'b0, 1'b1);
      i_master.stop_c;
      check({15'h0, busy}, 16'h0000, "idle after stop");
    end
    seed = lfsr(seed);
    p = {4'h0, seed[3:0]};
    @(posedge clk) sel <= seed[6:4];
    repeat (4) @(posedge clk);
    addr(seed[6:4], 1'b0, 1'b0);
    i_master.xfer(p, 8, rx);
    i_master.bit_x(1'b1, ack);
    check({15'h0, ack}, 16'h0000, "pointer ack");
    exp_q.push_back({p, seed[15:8]});
    i_master.xfer(seed[15:8], 8, rx);
    i_master.bit_x(1'b1, ack);
    check({15'h0, ack}, 16'h0000, "data ack");
    i_master.stop_c;
    check({8'h0, ptr}, {8'h0, p}, "pointer kept");
    // read from the kept pointer, three bytes
    addr(seed[6:4], 1'b1, 1'b0);
    for (int k = 0; k < 3; k++) begin
      exp_q.push_back({p + 8'(k), 8'h00});
      i_master.xfer(8'hff, 8, rx);
      check({8'h0, rx}, {8'h0, regs[p[3:0] + 4'(k)]}, "read byte");
      i_master.bit_x(k == 2, ack);
    end
    repeat (2) @(posedge clk);
    check({15'h0, sda_oe_n}, 16'h0001, "released after nak");
    i_master.stop_c;
    check({8'h0, ptr}, {8'h0, p + 8'h02}, "pointer advanced");
    // stop mid-byte, then repeated start mid-byte
    addr(seed[6:4], 1'b0, 1'b0);
    i_master.xfer(8'hff, 4, rx);
    i_master.stop_c;
    check({14'h0, busy, sda_oe_n}, 16'h0001, "abort on stop");
    addr(seed[6:4], 1'b0, 1'b0);
    i_master.xfer(8'h0f, 3, rx);
    addr(seed[6:4], 1'b1, 1'b0);
    exp_q.push_back({p + 8'h02, 8'h00});
    i_master.xfer(8'hff, 8, rx);
    check({8'h0, rx}, {8'h0, regs[p[3:0] + 4'h2]}, "read after restart");
    i_master.bit_x(1'b1, ack);
    i_master.stop_c;
    repeat (4) @(posedge clk);
    check(16'(exp_q.size()), 16'h0000, "all pulses seen");
    tally_and_finish;
  end
endmodule

// ---- sim/tcs_master_model.sv ----
// Purpose: two-wire bus master model driving the slave port
// Assumes: both wires pulled up in the bench
// Notes: 62.5 ns half period gives the 125 ns link clock, idle between frames
`timescale 1ns/10ps
module tcs_master_model (
  // wire levels
  input wire logic scl_i,
  input wire logic sda_i,
  // pull-down enables, high pulls the wire low
  output logic scl_low_o,
  output logic sda_low_o
);
  localparam realtime H = 62.5;
  // bus free time after a stop, 10 us
  localparam realtime BUS_FREE = 10000.0;

  // released at time zero
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  // data while scl low, wait out a stretch
  task automatic bit_x(input logic b, output logic r);
    int n = 0;
    sda_low_o = ~b;
    #(H/2);
    scl_low_o = 1'b0;
    while (scl_i !== 1'b1 && n < 500) begin
      #8;
      n++;
    end
    #(H/2);
    r = sda_i;
    #(H/2);
    scl_low_o = 1'b1;
    #(H/2);
  endtask

  task automatic start_c;
    sda_low_o = 1'b0;
    #(H/2);
    scl_low_o = 1'b0;
    #H;
    sda_low_o = 1'b1;
    #H;
    scl_low_o = 1'b1;
    #(H/2);
  endtask

  task automatic stop_c;
    sda_low_o = 1'b1;
    #(H/2);
    scl_low_o = 1'b0;
    #H;
    sda_low_o = 1'b0;
    #(BUS_FREE);
  endtask

  // msb first; short counts only to abort
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    logic b;
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      bit_x(tx[7-i], b);
      rx = {rx[6:0], b};
    end
  endtask
endmodule
